//--- rtl/addr_pkg.sv
`default_nettype none
package addr_pkg;
  // ------------------------------------------------------------
  // Register word offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [4:0] OFS_MODE  = 5'h00; // addressing_mode_reg
  localparam logic [4:0] OFS_STATE = 5'h04; // address_state_reg
  localparam logic [4:0] OFS_ST1   = 5'h08; // event_status_one
  localparam logic [4:0] OFS_ST2   = 5'h0C; // event_status_two
  localparam logic [4:0] OFS_MSK1  = 5'h10; // event_mask_one
  localparam logic [4:0] OFS_MSK2  = 5'h14; // event_mask_two
  localparam logic [4:0] OFS_PRI   = 5'h18; // primary_addr_reg
  localparam logic [4:0] OFS_SEC   = 5'h1C; // secondary_addr_reg
  // Write: bits 7:0 outgoing data byte; read: incoming byte
  localparam logic [5:0] OFS_DATA  = 6'h20;
  localparam logic [5:0] OFS_CMD   = 6'h24; // aux command / passthrough
  localparam logic [5:0] OFS_CFG   = 6'h28; // irq enable, end-of-string code
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int ST1_OUT = 0;  // output_ready_flag
  localparam int ST1_IN  = 1;  // input_ready_flag
  localparam int ST1_END = 2;
  localparam int ST1_SEC = 3;  // secondary_pending_flag
  localparam int ST2_ADR = 0;  // address_change_flag
  localparam int AS_SPK  = 0;  // speaker_active_bit
  localparam int AS_RCV  = 1;  // receiver_active_bit
  localparam int AS_SPS  = 2;  // speaker_primary_seen
  localparam int AS_RPS  = 3;  // receiver_primary_seen
  localparam int AS_MJ   = 4;  // major_minor_sel (1 = minor)
  // Aux commands
  localparam logic [7:0] CMD_VALID   = 8'h01;
  localparam logic [7:0] CMD_INVALID = 8'h02;
  localparam logic [7:0] CMD_EOI     = 8'h03;
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic [1:0]  RST_MODE   = 2'h1;  // addressing mode after reset
  localparam logic [7:0]  RST_EOS    = 8'h0A; // end-of-string code after reset
  // Bus byte coding
  typedef struct packed {
    logic       valid;
    logic       atn;
    logic       eoi;
    logic [7:0] data;
  } bus_byte_s;
endpackage
`default_nettype wire

//--- rtl/addr_unit.sv
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module addr_unit #(
  parameter logic [7:0] STATUS_ID = 8'h5A  // arbitrary id value
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [5:0]           adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic      [31:0]          dat_o,
  output logic                      ack_o,
  // Bus side: received byte, outgoing byte, handshake
  input  wire addr_pkg::bus_byte_s  rx_i,
  output logic                      rx_accept_o,
  output addr_pkg::bus_byte_s       tx_o,
  input  wire logic                 tx_taken_i,
  // Interrupt
  output logic                      irq_o,
  input  wire logic                 iack_i,
  output logic      [7:0]           iack_id_o
);
  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [1:0]  mode_q;
  logic [7:0]  pri_q, sec_q, msk1_q, msk2_q, cmdpt_q, din_q, eos_q;
  logic [3:0]  st1_q;
  logic        st2_q;
  logic        spk_q, rcv_q, sps_q, rps_q, mj_q, hold_q, pol_q;
  logic        prev_pri_q, eoi_pend_q, tx_full_q, rx_full_q, ack_q;
  logic [7:0]  txd_q;
  logic        tx_eoi_q, rel_q;

  wire logic   wr  = cyc_i & stb_i & we_i & ~ack_q & sel_i[0];
  wire logic   rd  = cyc_i & stb_i & ~we_i & ~ack_q;
  wire logic   rd1 = rd & (adr_i == {1'b0, addr_pkg::OFS_ST1});
  wire logic   rd2 = rd & (adr_i == {1'b0, addr_pkg::OFS_ST2});

  // ------------------------------------------------------------
  // Bus byte decode
  // ------------------------------------------------------------
  wire logic [4:0] ad   = rx_i.data[4:0];
  wire logic   cmd      = rx_i.valid & rx_i.atn & ~hold_q & ~rel_q;
  wire logic   is_lad   = cmd & (rx_i.data[6:5] == 2'b01);
  wire logic   is_tad   = cmd & (rx_i.data[6:5] == 2'b10);
  wire logic   is_sec   = cmd & (rx_i.data[6:5] == 2'b11);
  wire logic   is_pcg   = cmd & ~rx_i.data[6] | cmd & ~rx_i.data[5];
  // major and minor compare: major in pri, minor in sec
  wire logic   hit_mj   = (ad == pri_q[4:0]);
  // minor primary also in modes 0, 1 and 3
  wire logic   hit_mn   = (mode_q != 2'd2) & (ad == sec_q[4:0]);
  wire logic   hit_p    = hit_mj | hit_mn;
  wire logic   sec_hit  = (ad == sec_q[4:0]);
  wire logic   dbyte    = rx_i.valid & ~rx_i.atn & rcv_q & ~rx_full_q;
  wire logic   valid_c  = wr & (adr_i == addr_pkg::OFS_CMD) & (dat_i[7:0] == addr_pkg::CMD_VALID);
  wire logic   inval_c  = wr & (adr_i == addr_pkg::OFS_CMD) & (dat_i[7:0] == addr_pkg::CMD_INVALID);

  // ------------------------------------------------------------
  // Handshake: command bytes accepted at once, held under holdoff
  // ------------------------------------------------------------
  // accept held false while pending
  // held byte accepted once software answers
  assign rx_accept_o = rel_q ? rx_i.valid
                     : rx_i.valid & ~hold_q & (rx_i.atn | dbyte)
                       & ~(mode_q == 2'd3 & is_sec & prev_pri_q);

  // ------------------------------------------------------------
  // Holdoff release
  // ------------------------------------------------------------
  // release the stalled byte
  // One pulse suffices: the controller holds its byte until accepted,
  // and without it the same secondary would re-arm the holdoff
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rel_q <= 1'b0;
    end else begin
      rel_q <= hold_q & (valid_c | inval_c);
    end
  end

  // ------------------------------------------------------------
  // Address state machine
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spk_q <= 1'b0; rcv_q <= 1'b0; sps_q <= 1'b0; rps_q <= 1'b0;
      mj_q <= 1'b0; hold_q <= 1'b0; prev_pri_q <= 1'b0; cmdpt_q <= 8'h00;
    end else begin
      if (is_tad & hit_p) begin
        mj_q <= ~hit_mj;  // source of match
        if (mode_q == 2'd1) begin
          spk_q <= 1'b1;
          rcv_q <= 1'b0;  // exclusive
        end else begin
          sps_q <= 1'b1;  // primary seen
          rps_q <= 1'b0;
        end
        prev_pri_q <= 1'b1;
      end else if (is_lad & hit_p) begin
        mj_q <= ~hit_mj;
        if (mode_q == 2'd1) begin
          rcv_q <= 1'b1;
          spk_q <= 1'b0;
        end else begin
          rps_q <= 1'b1;  // primary seen
          sps_q <= 1'b0;
        end
        prev_pri_q <= 1'b1;
      end else if (is_pcg) begin
        sps_q <= 1'b0;
        rps_q <= 1'b0;
        prev_pri_q <= 1'b0;
      end else if (is_sec & prev_pri_q) begin
        if (mode_q == 2'd2 & sec_hit) begin
          spk_q <= sps_q;
          rcv_q <= rps_q;
        end else if (mode_q == 2'd3) begin
          hold_q  <= 1'b1;
          cmdpt_q <= rx_i.data;
        end
      end
      if (hold_q & valid_c) begin
        hold_q <= 1'b0;
        if (rps_q) begin
          rcv_q <= 1'b1;
          spk_q <= 1'b0;
        end else if (sps_q) begin
          spk_q <= 1'b1;
          rcv_q <= 1'b0;
        end
      end else if (hold_q & inval_c) begin
        hold_q <= 1'b0;
        if (sps_q) spk_q <= 1'b0;
        if (rps_q) rcv_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Data paths
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_full_q <= 1'b0; txd_q <= 8'h00; tx_eoi_q <= 1'b0;
      eoi_pend_q <= 1'b0; rx_full_q <= 1'b0; din_q <= 8'h00;
    end else begin
      if (wr & (adr_i == addr_pkg::OFS_CMD) & (dat_i[7:0] == addr_pkg::CMD_EOI))
        eoi_pend_q <= 1'b1;
      if (wr & (adr_i == addr_pkg::OFS_DATA) & ~tx_full_q) begin
        tx_full_q <= 1'b1;
        txd_q <= dat_i[7:0];
        tx_eoi_q <= eoi_pend_q;  // EOI marks this byte
        eoi_pend_q <= 1'b0;
      end else if (tx_full_q & tx_taken_i) begin
        tx_full_q <= 1'b0;
      end
      if (dbyte) begin
        rx_full_q <= 1'b1;
        din_q <= rx_i.data;
      end else if (rd & (adr_i == addr_pkg::OFS_DATA)) begin
        rx_full_q <= 1'b0;
      end
    end
  end
  assign tx_o = '{valid: tx_full_q & spk_q, atn: 1'b0, eoi: tx_eoi_q, data: txd_q};

  // ------------------------------------------------------------
  // Status flags: set beats clear-on-read
  // ------------------------------------------------------------
  logic [3:0] set1;
  logic       set2;
  logic       spk_d1_q, rcv_d1_q, out_rdy_q;
  always_comb begin
    set1 = 4'h0;
    // output ready on empty while talker
    set1[addr_pkg::ST1_OUT] = spk_q & ~tx_full_q & ~out_rdy_q;
    set1[addr_pkg::ST1_IN] = dbyte;
    set1[addr_pkg::ST1_END] = dbyte & (rx_i.eoi | rx_i.data == eos_q);
    set1[addr_pkg::ST1_SEC] = mode_q == 2'd3 & is_sec & prev_pri_q;
    // address change on a new talker or listener
    set2 = (spk_q & ~spk_d1_q) | (rcv_q & ~rcv_d1_q);
  end
  // Flags and edge history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st1_q <= 4'h0; st2_q <= 1'b0; spk_d1_q <= 1'b0; rcv_d1_q <= 1'b0;
      out_rdy_q <= 1'b0;
    end else begin
      spk_d1_q <= spk_q;
      rcv_d1_q <= rcv_q;
      out_rdy_q <= spk_q & ~tx_full_q;
      // read clears, new events still land
      st1_q <= (rd1 ? 4'h0 : st1_q) | set1;
      st2_q <= (rd2 ? 1'b0 : st2_q) | set2;
    end
  end

  // ------------------------------------------------------------
  // Interrupt: 13 sources in hardware, four + one implemented here
  // ------------------------------------------------------------
  // masked, enable bit, combinational drop
  wire logic any_irq = |(st1_q & msk1_q[3:0]) | (st2_q & msk2_q[0]);
  assign irq_o = pol_q ? any_irq : 1'b0;
  assign iack_id_o = iack_i ? STATUS_ID : 8'h00;

  // ------------------------------------------------------------
  // Software registers and Wishbone answer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= addr_pkg::RST_MODE; pri_q <= 8'h00; sec_q <= 8'h00; msk1_q <= 8'h00;
      msk2_q <= 8'h00; pol_q <= 1'b0; eos_q <= addr_pkg::RST_EOS; ack_q <= 1'b0;
      dat_o <= addr_pkg::RST_ZERO;
    end else begin
      ack_q <= cyc_i & stb_i & ~ack_q;
      if (wr) begin
        case (adr_i)
          {1'b0, addr_pkg::OFS_MODE}: mode_q <= dat_i[1:0];
          {1'b0, addr_pkg::OFS_PRI}:  pri_q  <= dat_i[7:0];
          {1'b0, addr_pkg::OFS_SEC}:  sec_q  <= dat_i[7:0];
          {1'b0, addr_pkg::OFS_MSK1}: msk1_q <= dat_i[7:0];
          {1'b0, addr_pkg::OFS_MSK2}: msk2_q <= dat_i[7:0];
          addr_pkg::OFS_CFG: begin
            pol_q <= dat_i[0];
            eos_q <= dat_i[15:8];
          end
          default: ;
        endcase
      end
      if (rd) begin
        case (adr_i)
          {1'b0, addr_pkg::OFS_MODE}:  dat_o <= {30'h0, mode_q};
          {1'b0, addr_pkg::OFS_STATE}: dat_o <= {27'h0, mj_q, rps_q, sps_q, rcv_q, spk_q};
          {1'b0, addr_pkg::OFS_ST1}:   dat_o <= {28'h0, st1_q};
          {1'b0, addr_pkg::OFS_ST2}:   dat_o <= {31'h0, st2_q};
          {1'b0, addr_pkg::OFS_MSK1}:  dat_o <= {24'h0, msk1_q};
          {1'b0, addr_pkg::OFS_MSK2}:  dat_o <= {24'h0, msk2_q};
          {1'b0, addr_pkg::OFS_PRI}:   dat_o <= {24'h0, pri_q};
          {1'b0, addr_pkg::OFS_SEC}:   dat_o <= {24'h0, sec_q};
          addr_pkg::OFS_DATA:          dat_o <= {24'h0, din_q};
          addr_pkg::OFS_CMD:           dat_o <= {24'h0, cmdpt_q};
          addr_pkg::OFS_CFG:           dat_o <= {16'h0, eos_q, 7'h0, pol_q};
          default:                     dat_o <= addr_pkg::RST_ZERO;
        endcase
      end
    end
  end
  assign ack_o = ack_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_excl;
    @(posedge clk_i) disable iff (rst_i) !(spk_q && rcv_q);
  endproperty
  a_excl: assert property (p_excl) else $error("talker and listener both");
  property p_hold;
    @(posedge clk_i) disable iff (rst_i) hold_q |-> !rx_accept_o;
  endproperty
  a_hold: assert property (p_hold) else $error("accept during holdoff");
  property p_m1tk;
    @(posedge clk_i) disable iff (rst_i) (mode_q == 2'd1 && is_tad && hit_p) |=> spk_q;
  endproperty
  a_m1tk: assert property (p_m1tk) else $error("talk address missed");
  property p_m1ls;
    @(posedge clk_i) disable iff (rst_i) (mode_q == 2'd1 && is_lad && hit_p) |=> rcv_q ##1 st2_q;
  endproperty
  a_m1ls: assert property (p_m1ls) else $error("listen address missed");
  property p_pcg;
    @(posedge clk_i) disable iff (rst_i)
      (is_pcg && !((is_tad || is_lad) && hit_p)) |=> !sps_q && !rps_q;
  endproperty
  a_pcg: assert property (p_pcg) else $error("seen bits not cleared");
  property p_apt;
    @(posedge clk_i) disable iff (rst_i)
      set1[addr_pkg::ST1_SEC] |=> hold_q && st1_q[addr_pkg::ST1_SEC];
  endproperty
  a_apt: assert property (p_apt) else $error("pending not raised");
  property p_inv;
    @(posedge clk_i) disable iff (rst_i) (hold_q && inval_c && sps_q) |=> !hold_q && !spk_q;
  endproperty
  a_inv: assert property (p_inv) else $error("invalid not idled");
  property p_val;
    @(posedge clk_i) disable iff (rst_i) (hold_q && valid_c && rps_q) |=> rcv_q && !spk_q;
  endproperty
  a_val: assert property (p_val) else $error("valid not taken");
  property p_irq;
    @(posedge clk_i) disable iff (rst_i) irq_o |-> pol_q && any_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("stray interrupt");
  property p_in;
    @(posedge clk_i) disable iff (rst_i) dbyte |=> st1_q[addr_pkg::ST1_IN];
  endproperty
  a_in: assert property (p_in) else $error("input ready missing");
  property p_rel;
    @(posedge clk_i) disable iff (rst_i)
      (hold_q && (valid_c || inval_c) && rx_i.valid) |=> rx_accept_o;
  endproperty
  a_rel: assert property (p_rel) else $error("held byte not released");
  property p_m2tk;
    @(posedge clk_i) disable iff (rst_i)
      (mode_q == 2'd2 && is_sec && prev_pri_q && sec_hit && sps_q) |=> spk_q && !rcv_q;
  endproperty
  a_m2tk: assert property (p_m2tk) else $error("extended talk missed");
  property p_m2ls;
    @(posedge clk_i) disable iff (rst_i)
      (mode_q == 2'd2 && is_sec && prev_pri_q && sec_hit && rps_q) |=> rcv_q && !spk_q;
  endproperty
  a_m2ls: assert property (p_m2ls) else $error("extended listen missed");
  property p_out;
    @(posedge clk_i) disable iff (rst_i)
      (spk_q && $fell(tx_full_q)) |=> st1_q[addr_pkg::ST1_OUT];
  endproperty
  a_out: assert property (p_out) else $error("output ready not raised");
  property p_end;
    @(posedge clk_i) disable iff (rst_i)
      (dbyte && rx_i.eoi) |=> st1_q[addr_pkg::ST1_END];
  endproperty
  a_end: assert property (p_end) else $error("end flag missing");
  property p_clr;
    @(posedge clk_i) disable iff (rst_i)
      (rd1 && set1 == 4'h0) |=> st1_q == 4'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("status one not cleared");
  property p_clr2;
    @(posedge clk_i) disable iff (rst_i)
      (rd2 && !set2) |=> !st2_q;
  endproperty
  a_clr2: assert property (p_clr2) else $error("status two not cleared");
  property p_adr;
    @(posedge clk_i) disable iff (rst_i)
      ($rose(spk_q) || $rose(rcv_q)) |=> st2_q;
  endproperty
  a_adr: assert property (p_adr) else $error("address change missing");
  property p_id;
    @(posedge clk_i) disable iff (rst_i)
      iack_i |-> iack_id_o == STATUS_ID;
  endproperty
  a_id: assert property (p_id) else $error("wrong status id");
  c_talk: cover property (@(posedge clk_i) disable iff (rst_i) $rose(spk_q));
  c_hold: cover property (@(posedge clk_i) disable iff (rst_i) $fell(hold_q));
  c_irq:  cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
  c_rel:  cover property (@(posedge clk_i) disable iff (rst_i) $rose(rel_q));
  c_rx:   cover property (@(posedge clk_i) disable iff (rst_i) $rose(rx_full_q));
endmodule
`default_nettype wire

//--- sim/bus_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_ctl_model (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Bytes towards the device
  output addr_pkg::bus_byte_s      rx_o,
  input  wire logic                rx_accept_i,
  // Bytes from the device
  input  wire addr_pkg::bus_byte_s tx_i,
  output logic                     tx_taken_o
);
  // ------------------------------------------------------------
  // Listener side: slow acceptance of talker bytes
  // ------------------------------------------------------------
  logic [1:0] wait_q;

  // Lines start idle
  initial begin
    rx_o = '0;
  end

  // all listeners accept, after a few cycles
  always @(posedge clk_i) begin
    if (rst_i || !tx_i.valid || tx_taken_o) begin
      wait_q <= 2'd0;
      tx_taken_o <= 1'b0;
    end else begin
      wait_q <= wait_q + 2'd1;
      tx_taken_o <= (wait_q == 2'd3);
    end
  end

  // Controller holds each byte until accepted, through any holdoff
  task automatic send(input logic atn, input logic eoi, input logic [7:0] d);
    @(posedge clk_i);
    rx_o <= '{valid: 1'b1, atn: atn, eoi: eoi, data: d};
    do @(posedge clk_i); while (rx_accept_i !== 1'b1);
    // Released lines show a changed pattern, never the old byte
    rx_o <= '{valid: 1'b0, atn: 1'b0, eoi: 1'b0, data: ~d};
  endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] cmd;
    logic [4:0] st;
    logic [3:0] s1;
    logic       s2;
  } row_s;
  localparam logic [7:0] ID = 8'h3C;  // arbitrary id value
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic iack_i = 1'b0, ack_o, rx_accept_o, tx_taken_i, irq_o;
  logic [5:0] adr_i = 6'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000, dat_o, r;
  logic [7:0] iack_id_o;
  addr_pkg::bus_byte_s rx_i, tx_o;
  int mismatches = 0, checked = 0, cycles = 0;
  row_s rows [4] = '{'{2'd1, 8'h45, 5'h01, 4'h1, 1'b1}, '{2'd1, 8'h29, 5'h12, 4'h0, 1'b1},
                     '{2'd1, 8'h47, 5'h00, 4'h0, 1'b0}, '{2'd2, 8'h45, 5'h04, 4'h0, 1'b0}};

  always #5 clk_i = ~clk_i;

  addr_unit #(.STATUS_ID(ID)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .rx_i(rx_i), .rx_accept_o(rx_accept_o), .tx_o(tx_o),
    .tx_taken_i(tx_taken_i), .irq_o(irq_o), .iack_i(iack_i), .iack_id_o(iack_id_o));
  bus_ctl_model ctl (.clk_i(clk_i), .rst_i(rst_i), .rx_o(rx_i), .rx_accept_i(rx_accept_o),
    .tx_i(tx_o), .tx_taken_o(tx_taken_i));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic results;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Classic single cycle, held until ack is seen
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Mode, primary 5, secondary or minor 9
  task automatic setup(input logic [1:0] m);
    do_reset();
    wb(1'b1, {1'b0, addr_pkg::OFS_MODE}, {30'd0, m});
    wb(1'b1, {1'b0, addr_pkg::OFS_PRI}, 32'h0000_0005);
    wb(1'b1, {1'b0, addr_pkg::OFS_SEC}, 32'h0000_0009);
  endtask

  // Hang guard, far above the expected run length
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      results();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    for (int i = 0; i < 4; i++) begin
      setup(rows[i].mode);
      ctl.send(1'b1, 1'b0, rows[i].cmd);
      wb(1'b0, {1'b0, addr_pkg::OFS_STATE}, 32'h0);
      `CHK(r[4:0], rows[i].st)
      wb(1'b0, {1'b0, addr_pkg::OFS_ST1}, 32'h0);
      `CHK(r[3:0], rows[i].s1)
      wb(1'b0, {1'b0, addr_pkg::OFS_ST2}, 32'h0);
      `CHK(r[0], rows[i].s2)
      $display("row %0d done", i);
    end
    // Mode 2: talk then listen, data with END and end code
    setup(2'd2);
    ctl.send(1'b1, 1'b0, 8'h45);
    ctl.send(1'b1, 1'b0, 8'h69);
    wb(1'b0, {1'b0, addr_pkg::OFS_STATE}, 32'h0);
    `CHK(r[0], 1'b1)
    ctl.send(1'b1, 1'b0, 8'h25);
    ctl.send(1'b1, 1'b0, 8'h69);
    wb(1'b0, {1'b0, addr_pkg::OFS_STATE}, 32'h0);
    `CHK(r[1:0], 2'b10)
    ctl.send(1'b0, 1'b1, 8'h3C);
    wb(1'b0, {1'b0, addr_pkg::OFS_ST1}, 32'h0);
    `CHK(r[2:1], 2'b11)
    wb(1'b0, addr_pkg::OFS_DATA, 32'h0);
    `CHK(r[7:0], 8'h3C)
    wb(1'b0, {1'b0, addr_pkg::OFS_ST1}, 32'h0);
    `CHK(r[3:0], 4'h0)
    ctl.send(1'b0, 1'b0, 8'h0A);
    wb(1'b0, {1'b0, addr_pkg::OFS_ST1}, 32'h0);
    `CHK(r[2:1], 2'b11)
    $display("mode 2 test done");
    // Mode 3: software-checked secondaries, valid then invalid
    setup(2'd3);
    ctl.send(1'b1, 1'b0, 8'h25);
    wb(1'b0, {1'b0, addr_pkg::OFS_STATE}, 32'h0);
    `CHK(r[3], 1'b1)
    // host reads pending and passthrough, then answers
    fork
      ctl.send(1'b1, 1'b0, 8'h6B);
      begin
        repeat (6) @(posedge clk_i);
        `CHK(rx_accept_o, 1'b0)
        wb(1'b0, {1'b0, addr_pkg::OFS_ST1}, 32'h0);
        `CHK(r[3], 1'b1)
        wb(1'b0, addr_pkg::OFS_CMD, 32'h0);
        `CHK(r[4:0], 5'h0B)
        wb(1'b1, addr_pkg::OFS_CMD, {24'd0, addr_pkg::CMD_VALID});
      end
    join
    wb(1'b0, {1'b0, addr_pkg::OFS_STATE}, 32'h0);
    `CHK(r[1:0], 2'b10)
    fork
      ctl.send(1'b1, 1'b0, 8'h6C);
      begin
        repeat (6) @(posedge clk_i);
        `CHK(rx_accept_o, 1'b0)
        wb(1'b1, addr_pkg::OFS_CMD, {24'd0, addr_pkg::CMD_INVALID});
      end
    join
    wb(1'b0, {1'b0, addr_pkg::OFS_STATE}, 32'h0);
    `CHK(r[1:0], 2'b00)
    ctl.send(1'b1, 1'b0, 8'h14);
    wb(1'b0, {1'b0, addr_pkg::OFS_STATE}, 32'h0);
    `CHK(r[3:2], 2'b00)
    ctl.send(1'b1, 1'b0, 8'h49);
    wb(1'b0, {1'b0, addr_pkg::OFS_STATE}, 32'h0);
    `CHK(r[4], 1'b1)
    $display("mode 3 test done");
    // Talker data, interrupt and unmapped read
    setup(2'd1);
    wb(1'b1, addr_pkg::OFS_CFG, 32'h0000_0001);
    wb(1'b1, {1'b0, addr_pkg::OFS_MSK1}, 32'h0000_0001);
    ctl.send(1'b1, 1'b0, 8'h45);
    repeat (2) @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    wb(1'b0, {1'b0, addr_pkg::OFS_ST1}, 32'h0);
    `CHK(irq_o, 1'b0)
    iack_i <= 1'b1;
    @(posedge clk_i);
    `CHK(iack_id_o, ID)
    iack_i <= 1'b0;
    wb(1'b1, addr_pkg::OFS_CMD, {24'd0, addr_pkg::CMD_EOI});
    wb(1'b1, addr_pkg::OFS_DATA, 32'h0000_00A5);
    `CHK({tx_o.valid, tx_o.atn, tx_o.eoi, tx_o.data}, {3'b101, 8'hA5})
    repeat (8) @(posedge clk_i);
    wb(1'b0, {1'b0, addr_pkg::OFS_ST1}, 32'h0);
    `CHK(r[0], 1'b1)
    wb(1'b0, 6'h3C, 32'h0);
    `CHK(r, 32'h0000_0000)
    $display("talker test done");
    // Mid-run reset restores mode and end code, drops the request
    do_reset();
    wb(1'b0, {1'b0, addr_pkg::OFS_MODE}, 32'h0);
    `CHK(r, {30'h0, addr_pkg::RST_MODE})
    wb(1'b0, addr_pkg::OFS_CFG, 32'h0);
    `CHK(r, {16'h0, addr_pkg::RST_EOS, 8'h00})
    `CHK(irq_o, 1'b0)
    $display("reset test done");
    results();
  end
endmodule
`default_nettype wire
